/* File: core/adsyn_div.sv */
// Purpose: programmable clock divider, divide by ratio plus one
// Assumes: in_tick pulses once per rising edge of in_clk
// Notes: output lags input by one aclk cycle; idle output is low

`timescale 1ns/1ps

module adsyn_div
   import adsyn_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // control
   input wire logic enable,
   input wire logic [3:0] ratio,
   // source clock
   input wire logic in_clk,
   input wire logic in_tick,
   // divided clock
   output logic out_clk,
   output logic out_tick
);

   typedef struct packed {
      logic [3:0] cnt;
      logic clk;
      logic tick;
   } adsyn_div_t;

   adsyn_div_t s_ff;
   adsyn_div_t nxt_s;

   // ****************************************
   // divide logic
   // ****************************************
   always_comb begin
      nxt_s = s_ff;
      nxt_s.tick = 1'b0;
      if (!enable) begin
         nxt_s = '0;
      end else begin
         if (in_tick) begin
            if (s_ff.cnt == ratio) begin
               nxt_s.cnt = 4'h0;
               nxt_s.tick = 1'b1;
            end else begin
               nxt_s.cnt = s_ff.cnt + 4'h1;
            end
         end
         if (ratio == 4'h0) begin
            nxt_s.clk = in_clk;
         end else begin
            nxt_s.clk = (nxt_s.cnt <= (ratio >> 1));
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign out_clk = s_ff.clk;
   assign out_tick = s_ff.tick;

endmodule // adsyn_div

/* File: core/adsyn_pkg.sv */
// Purpose: constants for the adaptive audio clock synthesizer registers
// Assumes: one clock domain, AXI4-Lite register access, byte-wide registers
// Notes: register byte address is four times the register index
//
// Overview of operation
// - Bits 7..0 of the 24-bit frequency word live in their own byte register.
// - Bits 15..8 of the frequency word sit in a read/write byte that resets to zero.
// - Bits 23..16 of the frequency word sit in a read/write byte that resets to zero.
// - The full 24-bit word sets the synthesizer rate that makes the master clock.
// - A 16-bit free-running counter steps once per cycle of the chosen master clock.
// - Each USB start of frame copies the counter into the snapshot with no software help.
// - The snapshot reads back as low and high read-only bytes, both resetting to zero.
// - Control bit 5 picks the counter clock: 0 primary output, 1 secondary output.
// - With the synthesizer unused, control bit 4 picks external input primary or secondary.
// - Control bit 6 enables the primary master clock output driver when set.
// - Divider bits 7..4 divide the output clock by the field value plus one.
// - Divider bits 2..0 divide the input clock by the field value plus one.
// - Control bit 2 enables both dividers; both stay idle while it is clear.
// - Reserved bits read as zero and ignore writes.

package adsyn_pkg;

   // ****************************************
   // register indices
   // ****************************************
   localparam logic [15:0] ADSYN_IDX_CTL = 16'hffe1;
   localparam logic [15:0] ADSYN_IDX_DIV = 16'hffe2;
   localparam logic [15:0] ADSYN_IDX_SNAP_HI = 16'hffe3;
   localparam logic [15:0] ADSYN_IDX_SNAP_LO = 16'hffe4;
   localparam logic [15:0] ADSYN_IDX_FRQ_HI = 16'hffe5;
   localparam logic [15:0] ADSYN_IDX_FRQ_MID = 16'hffe6;
   localparam logic [15:0] ADSYN_IDX_FRQ_LO = 16'hffe7;
   localparam logic [15:0] ADSYN_IDX_SRC = 16'hfff0;

   // ****************************************
   // field positions and writable masks
   // ****************************************
   localparam int ADSYN_CTL_OUT_EN = 6;
   localparam int ADSYN_CTL_CNT_SEL = 5;
   localparam int ADSYN_CTL_IN_SEL = 4;
   localparam int ADSYN_CTL_DIV_EN = 2;
   localparam logic [7:0] ADSYN_CTL_MASK = 8'h74;
   localparam int ADSYN_DIV_OUT_LSB = 4;
   localparam int ADSYN_DIV_IN_LSB = 0;
   localparam logic [7:0] ADSYN_DIV_MASK = 8'hf7;
   localparam int ADSYN_SRC_EXT = 0;
   localparam logic [7:0] ADSYN_SRC_MASK = 8'h01;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] ADSYN_CTL_RST = 8'h00;
   localparam logic [7:0] ADSYN_DIV_RST = 8'h00;
   localparam logic [23:0] ADSYN_FRQ_RST = 24'h000000;
   localparam logic [15:0] ADSYN_SNAP_RST = 16'h0000;
   localparam logic [7:0] ADSYN_SRC_RST = 8'h00;

   // ****************************************
   // bus responses
   // ****************************************
   localparam logic [1:0] ADSYN_RESP_OKAY = 2'h0;
   localparam logic [1:0] ADSYN_RESP_SLVERR = 2'h2;

endpackage : adsyn_pkg

/* File: core/adsyn_regs.sv */
// Purpose: adaptive audio master clock synthesizer with byte registers on AXI4-Lite
// Assumes: external clock inputs and frame start are asynchronous pins
// Notes: synthesizer is a 24-bit phase accumulator stepping once per aclk

`timescale 1ns/1ps

module adsyn_regs
   import adsyn_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   // axi write data
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // axi write response
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // axi read address
   input wire logic arvalid,
   output logic arready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   // axi read data
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // external clock inputs
   input wire logic master_clock_in,
   input wire logic master_clock_in_secondary,
   // usb frame start
   input wire logic usb_sof,
   // master clock outputs
   output logic master_clock_out,
   output logic master_clock_out_en,
   output logic master_clock_out_secondary
);

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] dcfg;
      logic [7:0] src;
      logic [23:0] freq_word;
      logic [15:0] snap;
      logic [15:0] cnt;
      logic [23:0] acc;
      logic synth_d;
      logic ina_s1;
      logic ina_s2;
      logic ina_s3;
      logic inb_s1;
      logic inb_s2;
      logic inb_s3;
      logic sof_s1;
      logic sof_s2;
      logic sof_s3;
      logic mclk_o;
      logic mclk_o2;
      logic aw_got;
      logic [31:0] waddr;
      logic w_got;
      logic [7:0] wbyte;
      logic wlane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } adsyn_state_t;

   localparam adsyn_state_t ADSYN_S_RST = '{
      ctl: ADSYN_CTL_RST,
      dcfg: ADSYN_DIV_RST,
      src: ADSYN_SRC_RST,
      freq_word: ADSYN_FRQ_RST,
      snap: ADSYN_SNAP_RST,
      default: '0
   };

   adsyn_state_t s_ff;
   adsyn_state_t nxt_s;

   logic div_en;
   logic ext_src;
   logic ext_clk;
   logic ext_tick;
   logic synth_clk;
   logic synth_tick;
   logic idiv_clk;
   logic idiv_tick;
   logic src_clk;
   logic src_tick;
   logic odiv_clk;
   logic odiv_tick;
   logic cnt_tick;
   logic sof_edge;
   logic aw_take;
   logic w_take;
   logic ar_take;

   // ****************************************
   // register decode
   // ****************************************
   function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
      hit = (addr[31:2] == {14'h0000, idx}) && (addr[1:0] == 2'h0);
   endfunction

   function automatic logic mapped(input logic [31:0] addr);
      mapped = hit(addr, ADSYN_IDX_CTL) || hit(addr, ADSYN_IDX_DIV)
         || hit(addr, ADSYN_IDX_SNAP_HI) || hit(addr, ADSYN_IDX_SNAP_LO)
         || hit(addr, ADSYN_IDX_FRQ_HI) || hit(addr, ADSYN_IDX_FRQ_MID)
         || hit(addr, ADSYN_IDX_FRQ_LO) || hit(addr, ADSYN_IDX_SRC);
   endfunction

   function automatic logic [7:0] read_byte(input adsyn_state_t st, input logic [31:0] addr);
      read_byte = 8'h00;
      if (hit(addr, ADSYN_IDX_CTL)) begin
         read_byte = st.ctl & ADSYN_CTL_MASK;
      end else if (hit(addr, ADSYN_IDX_DIV)) begin
         read_byte = st.dcfg & ADSYN_DIV_MASK;
      end else if (hit(addr, ADSYN_IDX_SNAP_HI)) begin
         read_byte = st.snap[15:8];
      end else if (hit(addr, ADSYN_IDX_SNAP_LO)) begin
         read_byte = st.snap[7:0];
      end else if (hit(addr, ADSYN_IDX_FRQ_HI)) begin
         read_byte = st.freq_word[23:16];
      end else if (hit(addr, ADSYN_IDX_FRQ_MID)) begin
         read_byte = st.freq_word[15:8];
      end else if (hit(addr, ADSYN_IDX_FRQ_LO)) begin
         read_byte = st.freq_word[7:0];
      end else if (hit(addr, ADSYN_IDX_SRC)) begin
         read_byte = st.src & ADSYN_SRC_MASK;
      end
   endfunction

   // ****************************************
   // clock path
   // ****************************************
   assign div_en = s_ff.ctl[ADSYN_CTL_DIV_EN];
   assign ext_src = s_ff.src[ADSYN_SRC_EXT];

   // external input choice, read from second and third stages only
   assign ext_clk = s_ff.ctl[ADSYN_CTL_IN_SEL] ? s_ff.inb_s2 : s_ff.ina_s2;
   assign ext_tick = s_ff.ctl[ADSYN_CTL_IN_SEL] ? (s_ff.inb_s2 & ~s_ff.inb_s3)
      : (s_ff.ina_s2 & ~s_ff.ina_s3);

   assign synth_clk = s_ff.acc[23];
   assign synth_tick = s_ff.acc[23] & ~s_ff.synth_d;

   adsyn_div u_in_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(div_en),
      .ratio({1'b0, s_ff.dcfg[ADSYN_DIV_IN_LSB +: 3]}),
      .in_clk(ext_clk),
      .in_tick(ext_tick),
      .out_clk(idiv_clk),
      .out_tick(idiv_tick)
   );

   assign src_clk = ext_src ? idiv_clk : synth_clk;
   assign src_tick = ext_src ? idiv_tick : synth_tick;

   adsyn_div u_out_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .enable(div_en),
      .ratio(s_ff.dcfg[ADSYN_DIV_OUT_LSB +: 4]),
      .in_clk(src_clk),
      .in_tick(src_tick),
      .out_clk(odiv_clk),
      .out_tick(odiv_tick)
   );

   assign cnt_tick = s_ff.ctl[ADSYN_CTL_CNT_SEL] ? (src_tick & div_en) : odiv_tick;
   assign sof_edge = s_ff.sof_s2 & ~s_ff.sof_s3;

   // ****************************************
   // bus handshakes
   // ****************************************
   assign awready = !s_ff.aw_got && !s_ff.bvalid;
   assign wready = !s_ff.w_got && !s_ff.bvalid;
   assign arready = !s_ff.rvalid;
   assign aw_take = awvalid && awready;
   assign w_take = wvalid && wready;
   assign ar_take = arvalid && arready;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      nxt_s = s_ff;

      // synchronisers
      nxt_s.ina_s1 = master_clock_in;
      nxt_s.ina_s2 = s_ff.ina_s1;
      nxt_s.ina_s3 = s_ff.ina_s2;
      nxt_s.inb_s1 = master_clock_in_secondary;
      nxt_s.inb_s2 = s_ff.inb_s1;
      nxt_s.inb_s3 = s_ff.inb_s2;
      nxt_s.sof_s1 = usb_sof;
      nxt_s.sof_s2 = s_ff.sof_s1;
      nxt_s.sof_s3 = s_ff.sof_s2;

      // synthesizer
      nxt_s.acc = s_ff.acc + s_ff.freq_word;
      nxt_s.synth_d = s_ff.acc[23];

      // output pins
      nxt_s.mclk_o2 = src_clk & div_en;

      // cycle counter and frame snapshot
      if (cnt_tick) begin
         nxt_s.cnt = s_ff.cnt + 16'h0001;
      end
      if (sof_edge) begin
         nxt_s.snap = s_ff.cnt;
      end

      // write channel capture
      if (aw_take) begin
         nxt_s.aw_got = 1'b1;
         nxt_s.waddr = awaddr;
      end
      if (w_take) begin
         nxt_s.w_got = 1'b1;
         nxt_s.wbyte = wdata[7:0];
         nxt_s.wlane = wstrb[0];
      end

      // register write once address and data are both held
      if (s_ff.aw_got && s_ff.w_got) begin
         nxt_s.aw_got = 1'b0;
         nxt_s.w_got = 1'b0;
         nxt_s.bvalid = 1'b1;
         nxt_s.bresp = mapped(s_ff.waddr) ? ADSYN_RESP_OKAY : ADSYN_RESP_SLVERR;
         if (s_ff.wlane) begin
            if (hit(s_ff.waddr, ADSYN_IDX_CTL)) begin
               nxt_s.ctl = s_ff.wbyte & ADSYN_CTL_MASK;
            end
            if (hit(s_ff.waddr, ADSYN_IDX_DIV)) begin
               nxt_s.dcfg = s_ff.wbyte & ADSYN_DIV_MASK;
            end
            if (hit(s_ff.waddr, ADSYN_IDX_FRQ_HI)) begin
               nxt_s.freq_word[23:16] = s_ff.wbyte;
            end
            if (hit(s_ff.waddr, ADSYN_IDX_FRQ_MID)) begin
               nxt_s.freq_word[15:8] = s_ff.wbyte;
            end
            if (hit(s_ff.waddr, ADSYN_IDX_FRQ_LO)) begin
               nxt_s.freq_word[7:0] = s_ff.wbyte;
            end
            if (hit(s_ff.waddr, ADSYN_IDX_SRC)) begin
               nxt_s.src = s_ff.wbyte & ADSYN_SRC_MASK;
            end
         end
      end
      if (s_ff.bvalid && bready) begin
         nxt_s.bvalid = 1'b0;
      end

      // read channel
      if (ar_take) begin
         nxt_s.rvalid = 1'b1;
         nxt_s.rdata = {24'h000000, read_byte(s_ff, araddr)};
         nxt_s.rresp = mapped(araddr) ? ADSYN_RESP_OKAY : ADSYN_RESP_SLVERR;
      end else if (s_ff.rvalid && rready) begin
         nxt_s.rvalid = 1'b0;
      end

      // primary pin gated by the enable it will show next cycle
      nxt_s.mclk_o = odiv_clk & nxt_s.ctl[ADSYN_CTL_OUT_EN];
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_ff <= ADSYN_S_RST;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign bvalid = s_ff.bvalid;
   assign bresp = s_ff.bresp;
   assign rvalid = s_ff.rvalid;
   assign rdata = s_ff.rdata;
   assign rresp = s_ff.rresp;
   assign master_clock_out = s_ff.mclk_o;
   assign master_clock_out_en = s_ff.ctl[ADSYN_CTL_OUT_EN];
   assign master_clock_out_secondary = s_ff.mclk_o2;

endmodule // adsyn_regs

/* File: verif/adsyn_codec_model.sv */
// Purpose: codec stand-in counting master clock rising edges
// Assumes: clocks slower than half of aclk
// Notes: primary pin is seen only while its driver is enabled
`timescale 1ns/1ps
module adsyn_codec_model (
   // clock and control
   input wire logic aclk,
   input wire logic clr,
   // master clock pins
   input wire logic master_clock_out,
   input wire logic master_clock_out_en,
   input wire logic master_clock_out_secondary,
   // edge counts
   output logic [15:0] edges,
   output logic [15:0] edges2
);
   logic p_ff;
   logic p2_ff;
   logic pin;
   assign pin = master_clock_out & master_clock_out_en;
   always_ff @(posedge aclk) begin
      p_ff <= pin;
      p2_ff <= master_clock_out_secondary;
      edges <= clr ? 16'h0 : edges + 16'(pin & !p_ff);
      edges2 <= clr ? 16'h0 : edges2 + 16'(master_clock_out_secondary & !p2_ff);
   end
endmodule // adsyn_codec_model

/* File: verif/adsyn_regs_asserts.sv */
// Purpose: concurrent checks on the adsyn_regs ports
// Assumes: one clock domain, synchronous active-low reset
// Notes: attached to every adsyn_regs instance by bind
`timescale 1ns/1ps
module adsyn_regs_asserts
   import adsyn_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   // master clock pins
   input wire logic master_clock_out,
   input wire logic master_clock_out_en,
   input wire logic master_clock_out_secondary
);
   // ****************************************
   // read address tracking
   // ****************************************
   logic [31:0] rd_addr_ff;
   always_ff @(posedge aclk) begin
      if (arvalid && arready) begin
         rd_addr_ff <= araddr;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ****************************************
   // checks
   // ****************************************
   chk_ctl_reserved:
      assert property (rvalid && rd_addr_ff == {14'h0, ADSYN_IDX_CTL, 2'h0}
         |-> (rdata & 32'hffffff8b) == 32'h0) else $error("control reserved bits set");
   chk_div_reserved:
      assert property (rvalid && rd_addr_ff == {14'h0, ADSYN_IDX_DIV, 2'h0}
         |-> (rdata & 32'hffffff08) == 32'h0) else $error("divider reserved bits set");
   chk_rdata_upper:
      assert property (rvalid |-> rdata[31:8] == 24'h0) else $error("upper read bits set");
   chk_read_answer:
      assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
   chk_read_hold:
      assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("read data moved");
   chk_write_answer:
      assert property (awvalid && awready && wvalid && wready
         |=> !awready && !wready ##1 bvalid) else $error("write not answered");
   chk_resp_hold:
      assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("response moved");
   chk_out_gated:
      assert property (!master_clock_out_en |-> !master_clock_out) else $error("output not gated");
   chk_reset_idle:
      assert property ($rose(aresetn) |-> !master_clock_out && !master_clock_out_secondary)
         else $error("clock outputs not idle after reset");
   cover property (bvalid && bready && bresp == ADSYN_RESP_SLVERR);
   cover property ($rose(master_clock_out) && master_clock_out_en);
   cover property (rvalid && rready && rd_addr_ff == {14'h0, ADSYN_IDX_SNAP_LO, 2'h0});
endmodule // adsyn_regs_asserts

bind adsyn_regs adsyn_regs_asserts i_adsyn_regs_asserts (
   .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .bresp,
   .arvalid, .arready, .araddr, .rvalid, .rready, .rdata,
   .master_clock_out, .master_clock_out_en, .master_clock_out_secondary
);

/* File: verif/adsyn_regs_bench.sv */
// Purpose: self-checking bench for adsyn_regs
// Assumes: external clocks run at aclk/8 and aclk/16
// Notes: edge counts allow one edge of phase slack
`timescale 1ns/1ps
module adsyn_regs_bench
   import adsyn_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, usb_sof = 1'b0, clr = 1'b0;
   logic master_clock_in = 1'b0, master_clock_in_secondary = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic master_clock_out, master_clock_out_en, master_clock_out_secondary;
   logic [1:0] bresp, rresp;
   logic [15:0] cyc = 16'h0, ne, ne2;
   int n_mismatch = 0, checks_done = 0, t_cnt = 0;
   always #2 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc <= cyc + 16'h1;
      master_clock_in <= cyc[2];
      master_clock_in_secondary <= cyc[3];
      t_cnt++;
      if (t_cnt == 32'h4e20) begin
         n_mismatch++;
         finish_test();
      end
   end
   adsyn_regs i_adsyn_regs (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0),
      .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
      .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .master_clock_in,
      .master_clock_in_secondary, .usb_sof, .master_clock_out, .master_clock_out_en,
      .master_clock_out_secondary);
   adsyn_codec_model i_adsyn_codec_model (.aclk, .clr, .master_clock_out,
      .master_clock_out_en, .master_clock_out_secondary, .edges(ne), .edges2(ne2));
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic near(input logic [15:0] seen, input logic [15:0] e);
      chk({31'h0, (seen + 16'h1 >= e) && (seen <= e + 16'h1)}, 32'h1);
   endtask
   task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
      logic a;
      logic w;
      a = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= {14'h0, idx, 2'h0};
      wdata <= {24'h0, d};
      wstrb <= 4'h1;
      while (!(a && w)) begin
         @(posedge aclk);
         if (!a && awready) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] idx, output logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= {14'h0, idx, 2'h0};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata[7:0];
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic wc(input logic [15:0] i, input logic [7:0] d, input logic [1:0] e = 2'h0);
      logic [1:0] r;
      wr(i, d, r);
      chk({30'h0, r}, {30'h0, e});
   endtask
   task automatic rc(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = 2'h0);
      logic [7:0] d;
      logic [1:0] r;
      rd(i, d, r);
      chk({22'h0, r, d}, {22'h0, er, e});
   endtask
   task automatic measure();
      @(posedge aclk);
      clr <= 1'b1;
      @(posedge aclk);
      clr <= 1'b0;
      repeat (512) @(posedge aclk);
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      logic [15:0] ix [8] = '{ADSYN_IDX_CTL, ADSYN_IDX_DIV, ADSYN_IDX_SNAP_HI,
         ADSYN_IDX_SNAP_LO, ADSYN_IDX_FRQ_HI, ADSYN_IDX_FRQ_MID, ADSYN_IDX_FRQ_LO, ADSYN_IDX_SRC};
      foreach (ix[i]) rc(ix[i], 8'h00);
   endtask
   task automatic t_regs();
      logic [15:0] ix [3] = '{ADSYN_IDX_FRQ_HI, ADSYN_IDX_FRQ_MID, ADSYN_IDX_FRQ_LO};
      foreach (ix[i]) wc(ix[i], 8'ha5 ^ 8'(i));
      foreach (ix[i]) rc(ix[i], 8'ha5 ^ 8'(i));
      wc(ADSYN_IDX_CTL, 8'hff);
      rc(ADSYN_IDX_CTL, 8'h74);
      chk({31'h0, master_clock_out_en}, 32'h1);
      wc(ADSYN_IDX_DIV, 8'hff);
      rc(ADSYN_IDX_DIV, 8'hf7);
      wc(ADSYN_IDX_CTL, 8'h00);
      rc(ADSYN_IDX_CTL, 8'h00);
      chk({31'h0, master_clock_out_en}, 32'h0);
      wc(ADSYN_IDX_SNAP_LO, 8'hff);
      rc(ADSYN_IDX_SNAP_LO, 8'h00);
      wc(16'h0000, 8'h5a, ADSYN_RESP_SLVERR);
      rc(16'h0000, 8'h00, ADSYN_RESP_SLVERR);
   endtask
   task automatic t_synth();
      logic [7:0] hi [4] = '{8'h40, 8'h20, 8'h08, 8'h80};
      logic [7:0] dv [4] = '{8'h30, 8'h00, 8'hf0, 8'h70};
      logic [15:0] eo [4] = '{16'h20, 16'h40, 16'h1, 16'h20};
      logic [15:0] es [4] = '{16'h80, 16'h40, 16'h10, 16'h100};
      wc(ADSYN_IDX_FRQ_MID, 8'h00);
      wc(ADSYN_IDX_FRQ_LO, 8'h00);
      wc(ADSYN_IDX_CTL, 8'h40);
      foreach (hi[i]) begin
         wc(ADSYN_IDX_FRQ_HI, hi[i]);
         wc(ADSYN_IDX_DIV, dv[i]);
         wc(ADSYN_IDX_CTL, 8'h44);
         measure();
         near(ne, eo[i]);
         near(ne2, es[i]);
      end
      wc(ADSYN_IDX_CTL, 8'h40);
      measure();
      chk({ne, ne2}, 32'h0);
   endtask
   task automatic t_ext();
      logic [7:0] cv [4] = '{8'h44, 8'h54, 8'h44, 8'h54};
      logic [7:0] dv [4] = '{8'h00, 8'h00, 8'h07, 8'h11};
      logic [15:0] eo [4] = '{16'h40, 16'h20, 16'h8, 16'h8};
      logic [15:0] es [4] = '{16'h40, 16'h20, 16'h8, 16'h10};
      wc(ADSYN_IDX_SRC, 8'h01);
      foreach (cv[i]) begin
         wc(ADSYN_IDX_CTL, cv[i] & 8'hfb);
         wc(ADSYN_IDX_DIV, dv[i]);
         wc(ADSYN_IDX_CTL, cv[i]);
         measure();
         near(ne, eo[i]);
         near(ne2, es[i]);
      end
   endtask
   task automatic t_snap();
      logic [7:0] lo, hi;
      logic [1:0] r;
      logic [15:0] c0;
      logic [15:0] v [2];
      logic [7:0] cv [2] = '{8'h64, 8'h44};
      logic [15:0] ed [2] = '{16'h64, 16'h19};
      wc(ADSYN_IDX_SRC, 8'h00);
      wc(ADSYN_IDX_FRQ_HI, 8'h40);
      wc(ADSYN_IDX_DIV, 8'h30);
      foreach (cv[i]) begin
         wc(ADSYN_IDX_CTL, cv[i]);
         for (int k = 0; k < 2; k++) begin
            while (k == 1 && cyc != c0) @(posedge aclk);
            @(posedge aclk);
            usb_sof <= 1'b1;
            c0 = cyc + 16'h18f;
            repeat (8) @(posedge aclk);
            usb_sof <= 1'b0;
            repeat (8) @(posedge aclk);
            rd(ADSYN_IDX_SNAP_LO, lo, r);
            rd(ADSYN_IDX_SNAP_HI, hi, r);
            v[k] = {hi, lo};
         end
         chk({16'h0, v[1] - v[0]}, {16'h0, ed[i]});
      end
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_regs();
      t_synth();
      t_ext();
      t_snap();
      finish_test();
   end
endmodule // adsyn_regs_bench
